// >>> rpr_regs.sv
// Reference priority register bank for inputs seven to ten with AHB-Lite access.
// Assumes one system clock, word accesses only and availability from same-clock logic.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rpr_regs (
  // Clock, reset and enable.
  input  wire logic                          ref_clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          ce_i,
  // AHB-Lite slave.
  input  wire logic                          hsel_i,
  input  wire logic [rpr_pkg::ADDR_W-1:0]    haddr_i,
  input  wire logic [1:0]                    htrans_i,
  input  wire logic                          hwrite_i,
  input  wire logic [2:0]                    hsize_i,
  input  wire logic [rpr_pkg::DATA_W-1:0]    hwdata_i,
  input  wire logic                          hready_i,
  output logic                               hreadyout_o,
  output logic                               hresp_o,
  output logic      [rpr_pkg::DATA_W-1:0]    hrdata_o,
  // Reference availability and selection results.
  input  wire logic [rpr_pkg::NUM_REF-1:0]   ref_avail_i,
  output logic      [rpr_pkg::REF_IDX_W-1:0] main_sel_o,
  output logic                               main_found_o,
  output logic      [rpr_pkg::REF_IDX_W-1:0] aux_sel_o,
  output logic                               aux_found_o
);
  import rpr_pkg::*;

  logic [7:0]           prio_7_8  [NUM_PATH];
  logic [7:0]           prio_9_10 [NUM_PATH];
  logic                 path_bank_select;
  logic                 dp_write;
  logic                 dp_valid;
  logic [ADDR_W-1:0]    dp_idx;
  logic [REF_IDX_W-1:0] sel_best [NUM_PATH];
  logic                 sel_found [NUM_PATH];
  logic                 addr_take;
  logic                 wr_now;
  logic [ADDR_W-1:0]    addr_idx;
  logic [7:0]           next_prio_7_8;
  logic [7:0]           next_prio_9_10;
  logic [7:0]           rd_prio_7_8;
  logic [7:0]           rd_prio_9_10;
  logic                 next_path_sel;
  logic [DATA_W-1:0]    next_rdata;
  logic [DATA_W-1:0]    status_word;

  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] idx,
                                                  input logic [7:0] p78,
                                                  input logic [7:0] p910,
                                                  input logic psel,
                                                  input logic [DATA_W-1:0] st);
    logic [DATA_W-1:0] r;
    r = '0;
    if (idx == IDX_PRIO_7_8) begin
      r[7:0] = p78;
    end else if (idx == IDX_PRIO_9_10) begin
      r[7:0] = p910;
    end else if (idx == IDX_PATH_SEL) begin
      r[PATH_SEL_BIT] = psel;
    end else if (idx == IDX_SEL_STATUS) begin
      r = st;
    end
    return r;
  endfunction

  assign hreadyout_o = ce_i;
  assign hresp_o     = 1'b0;
  assign addr_take   = ce_i && hready_i && hsel_i && htrans_i[1];
  assign addr_idx    = {{ADDR_LSB{1'b0}}, haddr_i[ADDR_W-1:ADDR_LSB]};
  assign wr_now      = ce_i && dp_valid && dp_write;

  // Address phase capture.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx   <= '0;
    end else if (ce_i) begin
      dp_valid <= addr_take;
      dp_write <= addr_take && hwrite_i;
      dp_idx   <= addr_idx;
    end
  end

  // Values after the data phase write of this cycle, used for storage and read forwarding.
  always_comb begin
    next_prio_7_8  = prio_7_8[path_bank_select];
    next_prio_9_10 = prio_9_10[path_bank_select];
    next_path_sel  = path_bank_select;
    if (wr_now && (dp_idx == IDX_PRIO_7_8)) begin
      next_prio_7_8 = hwdata_i[7:0];
    end
    if (wr_now && (dp_idx == IDX_PRIO_9_10)) begin
      next_prio_9_10 = hwdata_i[7:0];
    end
    if (wr_now && (dp_idx == IDX_PATH_SEL)) begin
      next_path_sel = hwdata_i[PATH_SEL_BIT];
    end
  end

  // Only the copy chosen by the path-select bit is written.
  generate
    for (genvar p = 0; p < NUM_PATH; p++) begin : g_copy
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          prio_7_8[p]  <= RST_PRIO_7_8;
          prio_9_10[p] <= RST_PRIO_9_10;
        end else if (ce_i && (path_bank_select == p[0])) begin
          prio_7_8[p]  <= next_prio_7_8;
          prio_9_10[p] <= next_prio_9_10;
        end
      end

      rpr_sel_if sel_if ();
      assign sel_if.prio  = {prio_9_10[p][HI_NIB_LSB +: PRIO_W],
                             prio_9_10[p][LO_NIB_LSB +: PRIO_W],
                             prio_7_8[p][HI_NIB_LSB +: PRIO_W],
                             prio_7_8[p][LO_NIB_LSB +: PRIO_W]};
      assign sel_if.avail = ref_avail_i;
      assign sel_best[p]  = sel_if.best;
      assign sel_found[p] = sel_if.found;

      rpr_selector u_sel (
        .sel_if (sel_if.sel)
      );
    end
  endgenerate

  // Path-select bit.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      path_bank_select <= MAIN_TIMING_PATH;
    end else if (ce_i) begin
      path_bank_select <= next_path_sel;
    end
  end

  // Registered selection results.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      main_sel_o   <= '0;
      main_found_o <= 1'b0;
      aux_sel_o    <= '0;
      aux_found_o  <= 1'b0;
    end else if (ce_i) begin
      main_sel_o   <= sel_best[MAIN_TIMING_PATH];
      main_found_o <= sel_found[MAIN_TIMING_PATH];
      aux_sel_o    <= sel_best[AUX_TIMING_PATH];
      aux_found_o  <= sel_found[AUX_TIMING_PATH];
    end
  end

  always_comb begin
    status_word = '0;
    status_word[REF_IDX_W-1:0] = main_sel_o;
    status_word[ST_FOUND_BIT] = main_found_o;
    status_word[ST_AUX_LSB +: REF_IDX_W] = aux_sel_o;
    status_word[ST_AUX_LSB + ST_FOUND_BIT] = aux_found_o;
  end

  // A read that meets a path-select write sees the newly selected copy.
  assign rd_prio_7_8  = (next_path_sel == path_bank_select) ? next_prio_7_8
                                                            : prio_7_8[next_path_sel];
  assign rd_prio_9_10 = (next_path_sel == path_bank_select) ? next_prio_9_10
                                                            : prio_9_10[next_path_sel];

  assign next_rdata = read_mux(addr_idx, rd_prio_7_8, rd_prio_9_10,
                               next_path_sel, status_word);

  // Read data is captured at the address phase from post-write values.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hrdata_o <= '0;
    end else if (ce_i) begin
      if (addr_take && !hwrite_i) begin
        hrdata_o <= next_rdata;
      end else begin
        hrdata_o <= '0;
      end
    end
  end

  logic unused_ok;
  assign unused_ok = ^{hsize_i, htrans_i[0]};

endmodule // rpr_regs
`default_nettype wire

// >>> rpr_pkg.sv
// Constants, field layouts and reset values of the reference priority registers.
// Assumes a single system clock and an AHB-Lite master with word accesses only.
// Functional notes
// - Input eight upper nibble, input seven lower.
// - Smaller nonzero priority value wins selection.
// - Zero priority removes input from selection.
// - Path-select bit picks main or auxiliary copy.
// - Ten upper, nine lower; reset 1011 1010.
// - Every priority field reads back the last write to the copy picked by the path-select bit.
package rpr_pkg;

  localparam int unsigned ADDR_W  = 32;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned PRIO_W  = 4;
  localparam int unsigned NUM_REF = 4;
  localparam int unsigned REF_IDX_W = 2;
  localparam int unsigned NUM_PATH = 2;

  // Register indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_PRIO_7_8   = 32'h0000001B;
  localparam logic [ADDR_W-1:0] IDX_PRIO_9_10  = 32'h0000001C;
  localparam logic [ADDR_W-1:0] IDX_PATH_SEL   = 32'h0000004B;
  localparam logic [ADDR_W-1:0] IDX_SEL_STATUS = 32'h0000007E;
  localparam int unsigned       ADDR_LSB       = 2;

  localparam logic [7:0] RST_PRIO_7_8  = 8'h98;
  localparam logic [7:0] RST_PRIO_9_10 = 8'hBA;

  // Field positions.
  localparam int unsigned HI_NIB_LSB   = 4;
  localparam int unsigned LO_NIB_LSB   = 0;
  localparam int unsigned PATH_SEL_BIT = 4;
  localparam int unsigned ST_AUX_LSB   = 4;
  localparam int unsigned ST_FOUND_BIT = 2;

  localparam logic [PRIO_W-1:0] PRIO_OFF = 4'h0;
  localparam logic [1:0]        HTRANS_BUSY_OR_IDLE_MSB = 2'h2;

  localparam logic [0:0] MAIN_TIMING_PATH = 1'h0;
  localparam logic [0:0] AUX_TIMING_PATH  = 1'h1;

  typedef enum logic [1:0] {
    RPR_ACC_NONE   = 2'b00,
    RPR_ACC_PRIO78 = 2'b01,
    RPR_ACC_PRIO910 = 2'b10,
    RPR_ACC_OTHER  = 2'b11
  } rpr_acc_t;

endpackage : rpr_pkg

// >>> rpr_sel_if.sv
// Carrier between the register bank and one path's selection logic.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rpr_sel_if;
  import rpr_pkg::*;
  logic [NUM_REF*PRIO_W-1:0] prio;
  logic [NUM_REF-1:0]        avail;
  logic [REF_IDX_W-1:0]      best;
  logic                      found;
  modport bank (output prio, output avail, input best, input found);
  modport sel  (input prio, input avail, output best, output found);
endinterface : rpr_sel_if
`default_nettype wire

// >>> rpr_selector.sv
// Picks the preferred reference among inputs seven to ten for one timing path.
// Assumes priorities and availability are stable on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rpr_selector (
  rpr_sel_if.sel sel_if
);
  import rpr_pkg::*;

  logic [PRIO_W-1:0]    best_prio;
  logic [REF_IDX_W-1:0] best_idx;
  logic                 any;

  // Scanning upward with strict less-than keeps the lower input on ties.
  always_comb begin
    best_prio = PRIO_OFF;
    best_idx  = '0;
    any       = 1'b0;
    for (int i = 0; i < NUM_REF; i++) begin
      if (sel_if.avail[i] && (sel_if.prio[i*PRIO_W +: PRIO_W] != PRIO_OFF)) begin
        if (!any || (sel_if.prio[i*PRIO_W +: PRIO_W] < best_prio)) begin
          best_prio = sel_if.prio[i*PRIO_W +: PRIO_W];
          best_idx  = REF_IDX_W'(i);
          any       = 1'b1;
        end
      end
    end
  end

  assign sel_if.best  = best_idx;
  assign sel_if.found = any;

endmodule // rpr_selector
`default_nettype wire

// >>> rpr_regs_checker.sv
// Port checker for the reference priority register bank.
// Assumes one clock, hready looped back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module rpr_regs_checker
  import rpr_pkg::*;
(
  input wire logic        ref_clk_i, rstn_i, ce_i, hsel_i, hwrite_i, hready_i,
  input wire logic [1:0]  htrans_i,
  input wire logic [31:0] haddr_i, hwdata_i, hrdata_o,
  input wire logic        hreadyout_o, hresp_o, main_found_o, aux_found_o,
  input wire logic [1:0]  main_sel_o, aux_sel_o,
  input wire logic [3:0]  ref_avail_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire tk = hsel_i && htrans_i[1] && hready_i && ce_i;
  wire a78 = (haddr_i >> ADDR_LSB) == IDX_PRIO_7_8;
  AST_OKAY: assert property (hresp_o == 1'b0) else $error("bad response");
  AST_RDY: assert property (hreadyout_o == ce_i) else $error("ready differs");
  AST_IDLE: assert property (ce_i && !(tk && !hwrite_i) |=> hrdata_o == 32'h0)
    else $error("data outside data phase");
  AST_HI0: assert property (hrdata_o[31:8] == 24'h0) else $error("upper bits set");
  AST_UNMAP: assert property (tk && !hwrite_i && haddr_i[31:12] != 20'h0
    |=> hrdata_o == 32'h0) else $error("unmapped read data");
  AST_NONE: assert property (ce_i && ref_avail_i == 4'h0
    |=> !main_found_o && !aux_found_o) else $error("found with none available");
  AST_MAVL: assert property (main_found_o && $past(ce_i)
    |-> (($past(ref_avail_i) >> main_sel_o) & 4'h1) != 4'h0) else $error("main pick unavailable");
  AST_AAVL: assert property (aux_found_o && $past(ce_i)
    |-> (($past(ref_avail_i) >> aux_sel_o) & 4'h1) != 4'h0) else $error("aux pick unavailable");
  AST_WRRD: assert property (tk && hwrite_i && a78 ##1 hready_i ##1 tk && !hwrite_i && a78
    |=> hrdata_o[7:0] == $past(hwdata_i[7:0], 2)) else $error("read back differs");
  C_WR: cover property (tk && hwrite_i);
  C_RD: cover property (tk && !hwrite_i);
  C_MAIN: cover property (main_found_o && main_sel_o == 2'h1);
  C_AUX: cover property (aux_found_o && aux_sel_o == 2'h3);
endmodule // rpr_regs_checker
bind rpr_regs rpr_regs_checker u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
  .hsel_i(hsel_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .htrans_i(htrans_i),
  .haddr_i(haddr_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .main_found_o(main_found_o), .aux_found_o(aux_found_o),
  .main_sel_o(main_sel_o), .aux_sel_o(aux_sel_o), .ref_avail_i(ref_avail_i));
`default_nettype wire

// >>> test_ref_input_priority_regs.sv
// Self-checking bench of the priority register bank over AHB-Lite.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin samples_checked++; if ((g) !== (w)) begin num_errors++; \
  $display("unexpected %0t: got %h want %h", $time, g, w); end end
module test_ref_input_priority_regs;
  import rpr_pkg::*;
  localparam logic [31:0] A78 = IDX_PRIO_7_8 << ADDR_LSB;
  localparam logic [31:0] A910 = IDX_PRIO_9_10 << ADDR_LSB;
  localparam logic [31:0] APS = IDX_PATH_SEL << ADDR_LSB;
  localparam logic [31:0] ASTS = IDX_SEL_STATUS << ADDR_LSB;
  logic stall_en = 0;
  logic [5:0] got_sel;
  logic ref_clk_i = 0, rstn_i = 0, ce_i = 1, hsel_i = 0, hwrite_i = 0, rd_pend = 0, sel_req = 0;
  logic [1:0] htrans_i = 0, main_sel_o, aux_sel_o;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, seed = 32'hC46BB998, ew;
  logic [3:0] ref_avail_i = 0;
  logic hreadyout_o, hresp_o, main_found_o, aux_found_o;
  logic [7:0] mdl [2][2];
  logic [5:0] es;
  logic [31:0] rd_q[$];
  logic [5:0] sel_q[$];
  int num_errors = 0, samples_checked = 0;
  rpr_regs dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .ref_avail_i(ref_avail_i), .main_sel_o(main_sel_o),
    .main_found_o(main_found_o), .aux_sel_o(aux_sel_o), .aux_found_o(aux_found_o));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  // Random clock-enable gaps insert wait states while stalling is on.
  always @(posedge ref_clk_i) ce_i <= !stall_en || (rnd() % 32'd4 != 32'd0);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    wait_rdy();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy();
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    xfer(a, 1'b0, rnd());
  endtask
  task automatic sel(input logic [3:0] av, input logic [5:0] e);
    ref_avail_i <= av;
    repeat (3) @(posedge ref_clk_i);
    sel_q.push_back(e);
    sel_req <= 1'b1;
    @(posedge ref_clk_i);
    sel_req <= 1'b0;
  endtask
  // Compares each read data phase and each selection sample with the oldest note.
  always @(posedge ref_clk_i) begin
    if (rd_pend && hreadyout_o && rd_q.size() > 0) begin
      ew = rd_q.pop_front();
      `CHK(hrdata_o, ew)
    end
    if (sel_req && sel_q.size() > 0) begin
      es = sel_q.pop_front();
      got_sel = {main_found_o, main_sel_o & {2{main_found_o}}, aux_found_o,
                 aux_sel_o & {2{aux_found_o}}};
      `CHK(got_sel, es)
    end
    if (hreadyout_o) begin
      rd_pend <= hsel_i && htrans_i[1] && !hwrite_i;
    end
  end
  initial begin
    logic [31:0] v, d;
    logic p, r;
    mdl = '{'{8'h98, 8'hBA}, '{8'h98, 8'hBA}};
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      xfer(APS, 1'b1, 32'(i) << PATH_SEL_BIT);
      rd(APS, 32'(i) << PATH_SEL_BIT);
      rd(A78, 32'h98);
      rd(A910, 32'hBA);
    end
    stall_en <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      v = rnd();
      d = rnd();
      p = v[0];
      r = v[1];
      xfer(APS, 1'b1, {27'h0, p, 4'h0});
      xfer(r ? A910 : A78, 1'b1, d);
      mdl[p][r] = d[7:0];
      rd(r ? A910 : A78, {24'h0, d[7:0]});
      xfer(APS, 1'b1, {27'h0, !p, 4'h0});
      rd(r ? A910 : A78, {24'h0, mdl[!p][r]});
    end
    stall_en <= 1'b0;
    xfer(32'h0000F000, 1'b1, rnd());
    rd(32'h0000F000, 32'h0);
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(APS, 32'h0);
    rd(A78, 32'h98);
    rd(A910, 32'hBA);
    xfer(APS, 1'b1, 32'h10);
    rd(A78, 32'h98);
    xfer(APS, 1'b1, 32'h0);
    xfer(A78, 1'b1, 32'h21);
    rd(A78, 32'h21);
    xfer(A910, 1'b1, 32'h0);
    xfer(APS, 1'b1, 32'h10);
    xfer(A78, 1'b1, 32'h0);
    xfer(A910, 1'b1, 32'h12);
    sel(4'hF, 6'h27);
    rd(ASTS, 32'h74);
    sel(4'h6, 6'h2E);
    sel(4'hC, 6'h07);
    xfer(APS, 1'b1, 32'h0);
    xfer(A78, 1'b1, 32'h33);
    sel(4'h3, 6'h20);
    sel(4'h0, 6'h00);
    repeat (2) @(posedge ref_clk_i);
    complete_run();
  end
endmodule // test_ref_input_priority_regs
`default_nettype wire
